// *** rtl/pcrb_pkg.sv ***
// Package: address map, reset values, field layout and carriers of the PLL config bank
package pcrb_pkg;

   // ---------------------------------------------------------------
   // Register indices
   // ---------------------------------------------------------------
   localparam int NREG        = 18;
   localparam int IDX_L2_SINK = 0;
   localparam int IDX_L2_OFFS = 1;
   localparam int IDX_L2_BST  = 2;
   localparam int IDX_L2_CTRL = 3;
   localparam int IDX_INT     = 4;
   localparam int IDX_CAL_LO  = 5;
   localparam int IDX_CAL_HI  = 6;
   localparam int IDX_NUM0    = 7;
   localparam int IDX_DEN0    = 10;
   localparam int IDX_MOD     = 13;
   localparam int IDX_PUMP    = 14;
   localparam int IDX_CORES   = 15;
   localparam int IDX_SRCSNK  = 16;
   localparam int IDX_PD      = 17;

   // ---------------------------------------------------------------
   // Byte addresses, reset values and writable bits
   // ---------------------------------------------------------------
   localparam logic [15:0] REG_ADDR [NREG] = '{
      16'h0230, 16'h0231, 16'h0232, 16'h0233,
      16'h0240, 16'h0242, 16'h0243,
      16'h0244, 16'h0245, 16'h0246,
      16'h0248, 16'h0249, 16'h024A,
      16'h024C, 16'h024D, 16'h024E, 16'h024F, 16'h0250};
   localparam logic [7:0] REG_RESET [NREG] = '{
      8'h00, 8'h20, 8'hF0, 8'hE0,
      8'h0C, 8'h00, 8'h80,
      8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00,
      8'h00, 8'h80, 8'hFF, 8'hF0, 8'hE0};
   localparam logic [7:0] REG_MASK [NREG] = '{
      8'h0F, 8'h3F, 8'hF0, 8'hE1,
      8'hFF, 8'hFF, 8'hBF,
      8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'hFF, 8'hFF,
      8'h7E, 8'h80, 8'hFF, 8'hFF, 8'hE0};

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int L2_PD_BIT      = 7;
   localparam int L2_PFD_PD_BIT  = 6;
   localparam int L2_DIV_PD_BIT  = 5;
   localparam int L2_RSEL_BIT    = 0;
   localparam int CAL_EN_BIT     = 7;
   localparam int MOD_DITH_BIT   = 6;
   localparam int MOD_SHAPE_BIT  = 5;
   localparam int MOD_GAIN_LSB   = 3;
   localparam int MOD_ORDER_LSB  = 1;
   localparam int PUMP_EN_BIT    = 7;
   localparam int PD_ALL_BIT     = 7;
   localparam int PD_PFD_BIT     = 6;
   localparam int PD_DIV_BIT     = 5;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0] sink_enables;
      logic [5:0] pump_offset_code;
      logic [3:0] cascode_boost;
      logic       power_down;
      logic       detector_power_down;
      logic       divider_power_down;
      logic       reference_select;
   } pcrb_loop2_cfg_t;

   typedef struct packed {
      logic [3:0] sink_active;
      logic       detector_off;
      logic       divider_off;
      logic       pump_off;
   } pcrb_loop2_ctl_t;

   typedef struct packed {
      logic [7:0]  int_divider;
      logic [13:0] cal_ref_divider;
      logic        cal_enable;
      logic        cal_ref_from_loop2;
      logic [23:0] numerator;
      logic [23:0] denominator;
      logic        dither_enable;
      logic        dither_shaped;
      logic [1:0]  dither_gain;
      logic [1:0]  modulator_order;
      logic        pump_enable;
      logic [3:0]  cascode_boost;
      logic [3:0]  pump_core_enables;
      logic [3:0]  source_enables;
      logic [3:0]  sink_enables;
      logic        power_down_all;
      logic        detector_power_down;
      logic        divider_power_down;
   } pcrb_synth_cfg_t;

endpackage

// *** rtl/pcrb_byte_reg.sv ***
// One byte-wide configuration register with reset value and writable-bit mask
module pcrb_byte_reg #(
   parameter logic [7:0] RESET_VALUE = 8'h00,
   parameter logic [7:0] WRITE_MASK  = 8'hFF
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // Write side
   input  wire logic       we,
   input  wire logic [7:0] wdata,
   // Stored value
   output logic [7:0]      q
);

   // Masked-off bits hold zero forever, so reserved bits read as zero
   always_ff @(posedge clk)
   begin
      if (!nrst)
         q <= RESET_VALUE & WRITE_MASK;
      else if (we)
         q <= wdata & WRITE_MASK;
   end

endmodule

// *** rtl/pcrb_regfile.sv ***
// Configuration register bank for the second analog loop and the converter synth loop
//
// What this block does
// RULE1 - Sink bit n enables pump core n sink
// RULE2 - Six-bit pump offset code resets to 0x20
// RULE3 - Host leaves cascode boost at all ones
// RULE4 - Main power-down kills loop except oscillator
// RULE5 - Detector power-down bit resets to one
// RULE6 - Divider power-down bit resets to one
// RULE7 - Reference select: 0 first loop, 1 second
// RULE8 - Integer divider at 0x0240, reset 0x0C; SYNTH_CFG.int_divider is 0 in reset, 0x0C from the first edge after release
// RULE9 - Host programs 14-bit calibration divider bytes
// RULE10 - Calibration reference only from analog loops
// RULE11 - Numerator, denominator, options, power-downs mapped
// RULE12 - Calibration enable resets to one; SYNTH_CFG.cal_enable is 0 during reset, 1 from the first edge after release
// RULE13 - Reserved bits read zero, writes ignored
module pcrb_regfile (
   // Clock and reset
   input  wire logic                      CORE_CLK,
   input  wire logic                      NRST,
   // Configuration port
   input  wire logic [15:0]               CFG_ADDR,
   input  wire logic                      CFG_WR,
   input  wire logic [7:0]                CFG_WDATA,
   input  wire logic                      CFG_RD,
   output logic [7:0]                     CFG_RDATA,
   output logic                           CFG_RVALID,
   output logic                           CFG_HIT,
   // Second analog loop settings
   output pcrb_pkg::pcrb_loop2_cfg_t      LOOP2_CFG,
   output pcrb_pkg::pcrb_loop2_ctl_t      LOOP2_CTL,
   // Converter synth loop settings
   output pcrb_pkg::pcrb_synth_cfg_t      SYNTH_CFG
);

   // ---------------------------------------------------------------
   // Decode and storage
   // ---------------------------------------------------------------
   logic [7:0]              q [pcrb_pkg::NREG];
   logic [pcrb_pkg::NREG-1:0] hit;
   logic [7:0]              rd_sel [pcrb_pkg::NREG+1];

   assign rd_sel[0] = pcrb_pkg::UNMAPPED_READ;

   genvar g;
   generate
      for (g = 0; g < pcrb_pkg::NREG; g = g + 1)
      begin : regs
         wire logic we_g;
         assign hit[g] = (CFG_ADDR == pcrb_pkg::REG_ADDR[g]);  // RULE11
         assign we_g   = CFG_WR & hit[g];
         // Read data is an OR of one-hot selected bytes
         assign rd_sel[g+1] = rd_sel[g] | (hit[g] ? q[g] : 8'h00);
         pcrb_byte_reg #(
            .RESET_VALUE (pcrb_pkg::REG_RESET[g]),
            .WRITE_MASK  (pcrb_pkg::REG_MASK[g])          // RULE13
         ) u_reg (
            .clk   (CORE_CLK),
            .nrst  (NRST),
            .we    (we_g),
            .wdata (CFG_WDATA),
            .q     (q[g])
         );
      end
   endgenerate

   wire logic       any_hit = |hit;
   wire logic [7:0] next_rdata = rd_sel[pcrb_pkg::NREG];

   assign CFG_HIT = any_hit;

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   // Unmapped addresses return zero rather than stale data
   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST)
      begin
         CFG_RDATA  <= 8'h00;
         CFG_RVALID <= 1'b0;
      end
      else
      begin
         CFG_RVALID <= CFG_RD;
         if (CFG_RD)
            CFG_RDATA <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Second analog loop fields
   // ---------------------------------------------------------------
   pcrb_pkg::pcrb_loop2_cfg_t next_loop2;
   pcrb_pkg::pcrb_loop2_ctl_t next_ctl;
   wire logic [7:0] l2_ctrl = q[pcrb_pkg::IDX_L2_CTRL];

   assign next_loop2.sink_enables        = q[pcrb_pkg::IDX_L2_SINK][3:0];
   assign next_loop2.pump_offset_code    = q[pcrb_pkg::IDX_L2_OFFS][5:0];  // RULE2
   assign next_loop2.cascode_boost       = q[pcrb_pkg::IDX_L2_BST][7:4];
   assign next_loop2.power_down          = l2_ctrl[pcrb_pkg::L2_PD_BIT];      // RULE4
   assign next_loop2.detector_power_down = l2_ctrl[pcrb_pkg::L2_PFD_PD_BIT];  // RULE5
   assign next_loop2.divider_power_down  = l2_ctrl[pcrb_pkg::L2_DIV_PD_BIT];  // RULE6
   assign next_loop2.reference_select    = l2_ctrl[pcrb_pkg::L2_RSEL_BIT];    // RULE7

   // Main power-down overrides every block but the oscillator
   assign next_ctl.sink_active  = next_loop2.power_down ? 4'h0 : next_loop2.sink_enables;  // RULE1
   assign next_ctl.detector_off = next_loop2.power_down | next_loop2.detector_power_down;   // RULE4
   assign next_ctl.divider_off  = next_loop2.power_down | next_loop2.divider_power_down;    // RULE4
   assign next_ctl.pump_off     = next_loop2.power_down;                                    // RULE4

   // ---------------------------------------------------------------
   // Converter synth loop fields
   // ---------------------------------------------------------------
   pcrb_pkg::pcrb_synth_cfg_t next_synth;
   wire logic [7:0] cal_hi = q[pcrb_pkg::IDX_CAL_HI];
   wire logic [7:0] modb   = q[pcrb_pkg::IDX_MOD];
   wire logic [7:0] pdb    = q[pcrb_pkg::IDX_PD];

   assign next_synth.int_divider        = q[pcrb_pkg::IDX_INT];                       // RULE8
   assign next_synth.cal_ref_divider    = {cal_hi[5:0], q[pcrb_pkg::IDX_CAL_LO]};    // RULE9
   assign next_synth.cal_enable         = cal_hi[pcrb_pkg::CAL_EN_BIT];              // RULE12
   // Only two sources exist for the calibration reference
   assign next_synth.cal_ref_from_loop2 = next_loop2.reference_select;               // RULE10
   assign next_synth.numerator          = {q[pcrb_pkg::IDX_NUM0+2], q[pcrb_pkg::IDX_NUM0+1],
                                           q[pcrb_pkg::IDX_NUM0]};                   // RULE11
   assign next_synth.denominator        = {q[pcrb_pkg::IDX_DEN0+2], q[pcrb_pkg::IDX_DEN0+1],
                                           q[pcrb_pkg::IDX_DEN0]};                   // RULE11
   assign next_synth.dither_enable      = modb[pcrb_pkg::MOD_DITH_BIT];
   assign next_synth.dither_shaped      = modb[pcrb_pkg::MOD_SHAPE_BIT];
   assign next_synth.dither_gain        = modb[pcrb_pkg::MOD_GAIN_LSB +: 2];
   assign next_synth.modulator_order    = modb[pcrb_pkg::MOD_ORDER_LSB +: 2];
   assign next_synth.pump_enable        = q[pcrb_pkg::IDX_PUMP][pcrb_pkg::PUMP_EN_BIT];
   assign next_synth.cascode_boost      = q[pcrb_pkg::IDX_CORES][7:4];
   assign next_synth.pump_core_enables  = q[pcrb_pkg::IDX_CORES][3:0];
   assign next_synth.source_enables     = q[pcrb_pkg::IDX_SRCSNK][7:4];
   assign next_synth.sink_enables       = q[pcrb_pkg::IDX_SRCSNK][3:0];
   assign next_synth.power_down_all      = pdb[pcrb_pkg::PD_ALL_BIT];                // RULE11
   assign next_synth.detector_power_down = pdb[pcrb_pkg::PD_PFD_BIT];
   assign next_synth.divider_power_down  = pdb[pcrb_pkg::PD_DIV_BIT];

   // ---------------------------------------------------------------
   // Output registers
   // ---------------------------------------------------------------
   // One cycle of latency keeps analog controls glitch free
   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST)
      begin
         LOOP2_CFG <= '{sink_enables: 4'h0, pump_offset_code: 6'h20, cascode_boost: 4'hF,
                        power_down: 1'b1, detector_power_down: 1'b1,
                        divider_power_down: 1'b1, reference_select: 1'b0};
         LOOP2_CTL <= '{sink_active: 4'h0, detector_off: 1'b1, divider_off: 1'b1, pump_off: 1'b1};
         SYNTH_CFG <= '0;
      end
      else
      begin
         LOOP2_CFG <= next_loop2;
         LOOP2_CTL <= next_ctl;
         SYNTH_CFG <= next_synth;
      end
   end

endmodule

// *** bench/pcrb_regfile_properties.sv ***
// Concurrent checks on the configuration bank ports
module pcrb_regfile_properties (
   // Clock and reset
   input wire logic                       CORE_CLK,
   input wire logic                       NRST,
   // Configuration port
   input wire logic [15:0]                CFG_ADDR,
   input wire logic                       CFG_WR,
   input wire logic [7:0]                 CFG_WDATA,
   input wire logic                       CFG_RD,
   input wire logic [7:0]                 CFG_RDATA,
   input wire logic                       CFG_RVALID,
   input wire logic                       CFG_HIT,
   // Settings
   input wire pcrb_pkg::pcrb_loop2_cfg_t  LOOP2_CFG,
   input wire pcrb_pkg::pcrb_loop2_ctl_t  LOOP2_CTL,
   input wire pcrb_pkg::pcrb_synth_cfg_t  SYNTH_CFG
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   a_read_answer: assert property (CFG_RD |=> CFG_RVALID) else $error("read not answered");
   a_no_spurious: assert property (!CFG_RD |=> !CFG_RVALID) else $error("answer without read");
   a_rdata_hold: assert property (!CFG_RD |=> $stable(CFG_RDATA)) else $error("read data moved");
   a_unmapped_zero: assert property (CFG_RD && !CFG_HIT |=> CFG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_int_decode: assert property (CFG_ADDR == 16'h0240 |-> CFG_HIT) else $error("divider miss");
   a_gap_decode: assert property (CFG_ADDR inside {16'h0241, 16'h0247, 16'h024B} |-> !CFG_HIT)
      else $error("gap decoded");
   a_int_lands: assert property (CFG_WR && CFG_ADDR == 16'h0240 |=> ##1
      SYNTH_CFG.int_divider == $past(CFG_WDATA, 2)) else $error("divider not applied");
   a_sink_gate: assert property ($stable(LOOP2_CFG) |-> LOOP2_CTL.sink_active ==
      (LOOP2_CFG.power_down ? 4'h0 : LOOP2_CFG.sink_enables)) else $error("sink gating wrong");
   a_detector_gate: assert property ($stable(LOOP2_CFG) |-> LOOP2_CTL.detector_off ==
      (LOOP2_CFG.power_down | LOOP2_CFG.detector_power_down)) else $error("detector gating wrong");
   a_cal_source: assert property ($stable(LOOP2_CFG) |->
      SYNTH_CFG.cal_ref_from_loop2 == LOOP2_CFG.reference_select) else $error("cal source wrong");
endmodule

bind pcrb_regfile pcrb_regfile_properties pcrb_regfile_properties_inst (.CORE_CLK(CORE_CLK), .NRST(NRST),
   .CFG_ADDR(CFG_ADDR), .CFG_WR(CFG_WR), .CFG_WDATA(CFG_WDATA), .CFG_RD(CFG_RD), .CFG_RDATA(CFG_RDATA),
   .CFG_RVALID(CFG_RVALID), .CFG_HIT(CFG_HIT), .LOOP2_CFG(LOOP2_CFG), .LOOP2_CTL(LOOP2_CTL),
   .SYNTH_CFG(SYNTH_CFG));

// *** bench/pcrb_host_model.sv ***
// Host side of the configuration port: byte writes and reads
module pcrb_host_model (
   // Clock
   input  wire logic        CORE_CLK,
   // Request side
   output logic [15:0]      CFG_ADDR,
   output logic             CFG_WR,
   output logic [7:0]       CFG_WDATA,
   output logic             CFG_RD,
   // Answer side
   input  wire logic [7:0]  CFG_RDATA,
   input  wire logic        CFG_RVALID
);
   timeunit 1ns;
   timeprecision 100ps;
   logic lost = 1'b0;
   initial
   begin
      CFG_ADDR = 16'h0000;
      CFG_WDATA = 8'h00;
      CFG_WR = 1'b0;
      CFG_RD = 1'b0;
   end
   // Idle bus shows inverted last value so stale data never looks valid
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge CORE_CLK);
      #1;
      CFG_ADDR = a;
      CFG_WDATA = d;
      CFG_WR = 1'b1;
      @(posedge CORE_CLK);
      #1;
      CFG_WR = 1'b0;
      CFG_ADDR = ~a;
      CFG_WDATA = ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      int i;
      @(posedge CORE_CLK);
      #1;
      CFG_ADDR = a;
      CFG_RD = 1'b1;
      @(posedge CORE_CLK);
      #1;
      CFG_RD = 1'b0;
      CFG_ADDR = ~a;
      for (i = 0; i < 4 && CFG_RVALID !== 1'b1; i++)
      begin
         @(posedge CORE_CLK);
         #1;
      end
      if (CFG_RVALID !== 1'b1) lost = 1'b1;
      d = CFG_RDATA;
   endtask
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the configuration bank
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic CORE_CLK = 1'b0;
   logic NRST = 1'b0;
   logic [15:0] CFG_ADDR;
   logic CFG_WR, CFG_RD, CFG_RVALID, CFG_HIT;
   logic [7:0] CFG_WDATA, CFG_RDATA;
   pcrb_pkg::pcrb_loop2_cfg_t LOOP2_CFG;
   pcrb_pkg::pcrb_loop2_ctl_t LOOP2_CTL;
   pcrb_pkg::pcrb_synth_cfg_t SYNTH_CFG;
   int error_cnt = 0;
   int tests_run = 0;
   always #2.5 CORE_CLK = ~CORE_CLK;
   pcrb_host_model pcrb_host_model_inst (.CORE_CLK(CORE_CLK), .CFG_ADDR(CFG_ADDR), .CFG_WR(CFG_WR),
      .CFG_WDATA(CFG_WDATA), .CFG_RD(CFG_RD), .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID));
   pcrb_regfile pcrb_regfile_inst (.CORE_CLK(CORE_CLK), .NRST(NRST), .CFG_ADDR(CFG_ADDR), .CFG_WR(CFG_WR),
      .CFG_WDATA(CFG_WDATA), .CFG_RD(CFG_RD), .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID),
      .CFG_HIT(CFG_HIT), .LOOP2_CFG(LOOP2_CFG), .LOOP2_CTL(LOOP2_CTL), .SYNTH_CFG(SYNTH_CFG));
   task automatic tally_and_finish();
      if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] d;
      pcrb_host_model_inst.rd(a, d);
      if (pcrb_host_model_inst.lost)
      begin
         error_cnt++;
         tally_and_finish();
      end
      else
         chk("rdata", {24'h0, e}, {24'h0, d});
   endtask
   // Outputs land on the first edge after the write edge
   task automatic settle();
      @(posedge CORE_CLK);
      #1;
   endtask
   task automatic t_reset();
      for (int i = 0; i < pcrb_pkg::NREG; i++) rdchk(pcrb_pkg::REG_ADDR[i], pcrb_pkg::REG_RESET[i]);
      chk("loop2", {15'h0, 17'b0000_100000_1111_1110}, {15'h0, LOOP2_CFG});
      chk("int", 32'h0C, {24'h0, SYNTH_CFG.int_divider});
      chk("cal_en", 32'h1, {31'h0, SYNTH_CFG.cal_enable});
   endtask
   task automatic t_mask(input logic [7:0] v);
      logic [7:0] d;
      for (int i = 0; i < pcrb_pkg::NREG; i++)
      begin
         d = (i == pcrb_pkg::IDX_L2_BST) ? 8'hF0 : v;
         pcrb_host_model_inst.wr(pcrb_pkg::REG_ADDR[i], d);
         rdchk(pcrb_pkg::REG_ADDR[i], d & pcrb_pkg::REG_MASK[i]);
      end
   endtask
   task automatic t_fields();
      for (int i = 0; i < 3; i++)
      begin
         pcrb_host_model_inst.wr(16'h0244 + 16'(i), 8'h11 * 8'(i + 1));
         pcrb_host_model_inst.wr(16'h0248 + 16'(i), 8'h44 + 8'h11 * 8'(i));
      end
      pcrb_host_model_inst.wr(16'h0242, 8'hAB);
      pcrb_host_model_inst.wr(16'h0243, 8'h3F);
      pcrb_host_model_inst.wr(16'h0240, 8'hA5);
      settle();
      chk("num", 32'h332211, {8'h0, SYNTH_CFG.numerator});
      chk("den", 32'h665544, {8'h0, SYNTH_CFG.denominator});
      chk("calref", 32'h3FAB, {18'h0, SYNTH_CFG.cal_ref_divider});
      chk("cal_en", 32'h0, {31'h0, SYNTH_CFG.cal_enable});
      chk("int", 32'hA5, {24'h0, SYNTH_CFG.int_divider});
   endtask
   task automatic t_loop2();
      pcrb_host_model_inst.wr(16'h0230, 8'h05);
      pcrb_host_model_inst.wr(16'h0233, 8'h00);
      settle();
      chk("ctl_up", {25'h0, 7'b0101_000}, {25'h0, LOOP2_CTL});
      pcrb_host_model_inst.wr(16'h0233, 8'h81);
      settle();
      chk("ctl_pd", {25'h0, 7'b0000_111}, {25'h0, LOOP2_CTL});
      chk("calsrc", 32'h1, {31'h0, SYNTH_CFG.cal_ref_from_loop2});
      pcrb_host_model_inst.wr(16'h0233, 8'h40);
      settle();
      chk("ctl_pfd", {25'h0, 7'b0101_100}, {25'h0, LOOP2_CTL});
      pcrb_host_model_inst.wr(16'h0233, 8'h20);
      settle();
      chk("ctl_div", {25'h0, 7'b0101_010}, {25'h0, LOOP2_CTL});
   endtask
   task automatic t_unmapped();
      pcrb_host_model_inst.wr(16'h0241, 8'h5A);
      rdchk(16'h0241, 8'h00);
      rdchk(16'h0240, 8'hA5);
   endtask
   // Modulator, pump and power-down bytes must land in their own fields
   task automatic t_opts();
      pcrb_host_model_inst.wr(16'h024C, 8'h5A);
      pcrb_host_model_inst.wr(16'h024D, 8'h00);
      pcrb_host_model_inst.wr(16'h024E, 8'h3C);
      pcrb_host_model_inst.wr(16'h024F, 8'h96);
      pcrb_host_model_inst.wr(16'h0250, 8'h40);
      settle();
      chk("dsm", 32'h2D, {26'h0, SYNTH_CFG.dither_enable, SYNTH_CFG.dither_shaped,
          SYNTH_CFG.dither_gain, SYNTH_CFG.modulator_order});
      chk("pump", 32'h0, {31'h0, SYNTH_CFG.pump_enable});
      chk("cores", 32'h3C, {24'h0, SYNTH_CFG.cascode_boost, SYNTH_CFG.pump_core_enables});
      chk("srcsnk", 32'h96, {24'h0, SYNTH_CFG.source_enables, SYNTH_CFG.sink_enables});
      chk("pd", 32'h2, {29'h0, SYNTH_CFG.power_down_all, SYNTH_CFG.detector_power_down,
          SYNTH_CFG.divider_power_down});
   endtask
   // A reset in mid-run must bring the integer divider, cal enable, loop power-down and the 0x0233/0x0250 bytes back to default
   task automatic t_midreset();
      @(posedge CORE_CLK);
      #1;
      NRST = 1'b0;
      repeat (2) @(posedge CORE_CLK);
      #1;
      NRST = 1'b1;
      settle();
      chk("rst_int", 32'h0C, {24'h0, SYNTH_CFG.int_divider});
      chk("rst_cal_en", 32'h1, {31'h0, SYNTH_CFG.cal_enable});
      chk("rst_l2_pd", 32'h1, {31'h0, LOOP2_CFG.power_down});
      rdchk(16'h0233, pcrb_pkg::REG_RESET[pcrb_pkg::IDX_L2_CTRL]);
      rdchk(16'h0250, pcrb_pkg::REG_RESET[pcrb_pkg::IDX_PD]);
   endtask
   initial
   begin
      repeat (10) @(posedge CORE_CLK);
      #1;
      NRST = 1'b1;
      t_reset();
      t_mask(8'hFF);
      t_mask(8'h00);
      t_fields();
      t_loop2();
      t_unmapped();
      t_opts();
      t_midreset();
      tally_and_finish();
   end
endmodule
